// File: pkg/scm_map.svh
`ifndef SCM_MAP_SVH
`define SCM_MAP_SVH
// ==========================================
// Clock rates and frequency limits, in Hz
`define SCM_CLK_HZ 27'd40000000
`define SCM_FREQ_MIN_HZ 27'd10
`define SCM_FREQ_MAX_HZ 27'd105000000
`define SCM_BAND_LO_HZ 27'd2000000
`define SCM_BAND_HI_HZ 27'd4000000
`define SCM_EXT_FAST_MIN_HZ 27'd2000000
// Longest edge gap on the external fast clock, in clk cycles
`define SCM_EXT_GAP_CYC (`SCM_CLK_HZ / `SCM_EXT_FAST_MIN_HZ)
// ==========================================
// Waveform length limits, in samples
`define SCM_LEN_MIN 25'd24
`define SCM_LEN_MAX_SMALL 25'd4000000
`define SCM_LEN_MAX_LARGE 25'd16000000
`define SCM_FAST_STEP_MASK 25'h0000003
// ==========================================
// Reset values
`define SCM_RST_FREQ_HZ 27'd3000000
`endif

// File: pkg/scm_pkg.sv
package scm_pkg;
	typedef enum logic [2:0] {
		SCM_OP_NOP = 3'b000,
		SCM_OP_SET_FREQ = 3'b001,
		SCM_OP_SET_SRC = 3'b010,
		SCM_OP_LOAD_WAVE = 3'b011,
		SCM_OP_TRIGGER = 3'b100,
		SCM_OP_LOAD_SETUP = 3'b101,
		SCM_OP_STOP = 3'b110
	} scm_op_t;
	typedef enum logic [1:0] {
		SCM_ARG_NONE = 2'b00,
		SCM_ARG_SLOW = 2'b01,
		SCM_ARG_FAST = 2'b10
	} scm_mode_arg_t;
	typedef enum logic {
		SCM_MODE_SLOW = 1'b0,
		SCM_MODE_FAST = 1'b1
	} scm_mode_t;
	typedef enum logic [1:0] {
		SCM_SRC_INTERNAL = 2'b00,
		SCM_SRC_EXT_SLOW = 2'b01,
		SCM_SRC_EXT_FAST = 2'b10
	} scm_src_t;
	typedef enum logic {
		SCM_ST_IDLE = 1'b0,
		SCM_ST_RUN = 1'b1
	} scm_run_t;
	typedef struct packed {
		scm_op_t op;
		logic [26:0] freq_hz;
		scm_mode_arg_t mode_arg;
		scm_src_t src;
		logic [24:0] wave_len;
		logic segmented_waveform;
		logic [26:0] seg_freq_hz;
	} scm_cmd_t;
	typedef struct packed {
		logic freq_range;
		logic seg_locked;
		logic wave_short;
		logic wave_step;
		logic wave_long;
		logic ext_clock_low;
	} scm_err_t;
endpackage

// File: hw/scm_sample_clock.sv
`timescale 1ns/1ps
`include "scm_map.svh"
// Behaviour
// - Accept sample frequencies from 10 Hz to 105 MHz; fetch at that rate up to 40 MHz, once per clk above it.
// - Fetch one buffered sample per sample clock tick and present it.
// - Below 2 MHz force SLOW, above 4 MHz force FAST, ignore mode arg.
// - Between 2 and 4 MHz apply requested mode, else keep current mode.
// - SLOW mode allows lengths 24 up to 4M or 16M in single steps.
// - FAST mode requires length a multiple of four within same limits.
// - Loaded waveform breaking length or step limits posts matching errors.
// - Writing a frequency selects internal clock, connector becomes output.
// - External slow or fast makes connector an input fed by partner.
// - Segmented waveform blocks frequency change; query reports segment rate.
// - Power-up and setup load always return to internal clock.
// - External fast clock under 2 MHz halts output, warns, clears running.
module scm_sample_clock
	import scm_pkg::*;
(
	input wire logic clk, // 40 MHz system clock
	input wire logic resetn, // Asynchronous reset, active low
	input wire logic large_memory, // High on the larger-memory variant
	input wire logic cmd_valid, // Command strobe, one cycle
	input wire scm_cmd_t cmd, // Command payload
	input wire logic clk_conn_i, // Rear clock connector, input level
	output logic clk_conn_o, // Rear clock connector, driven level
	output logic clk_conn_oe, // Rear clock connector drive enable
	output logic sample_rd_en, // Sample fetch strobe to the buffer
	output logic [24:0] sample_addr, // Buffer address being fetched
	input wire logic [15:0] sample_data, // Buffer read data for sample_addr
	output logic [15:0] dac_data, // Sample presented to the converters
	output logic running, // Output running status bit
	output scm_mode_t mode, // Clock mode in effect
	output scm_src_t clock_source, // Selected clock source
	output logic [26:0] freq_report, // Frequency answer to a query
	output logic err_valid, // Error entries valid, one cycle
	output scm_err_t err // Error entries posted to the queue
);
	typedef struct packed {
		scm_src_t src;
		scm_mode_t mode;
		logic [26:0] freq;
		logic [26:0] seg_freq;
		logic segmented;
		logic loaded;
		logic [24:0] wave_len;
		scm_run_t run;
		logic [26:0] acc;
		logic [24:0] addr;
		logic ext_prev;
		logic [26:0] gap;
		logic conn;
		logic [15:0] dac;
		logic err_valid;
		scm_err_t err;
	} scm_state_t;

	scm_state_t st_reg;
	scm_state_t st_next;
	logic [1:0] rst_sync_reg;
	logic rst_n;
	logic tick;
	logic [27:0] acc_sum;
	logic [24:0] len_max;
	logic len_ok;
	logic in_range;

	// ==========================================
	// Reset release
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// ==========================================
	// Sample tick and length check
	assign acc_sum = {1'b0, st_reg.acc} + {1'b0, st_reg.freq};
	assign len_max = large_memory ? `SCM_LEN_MAX_LARGE : `SCM_LEN_MAX_SMALL;
	assign in_range = (cmd.freq_hz >= `SCM_FREQ_MIN_HZ) &&
		(cmd.freq_hz <= `SCM_FREQ_MAX_HZ);
	assign len_ok = st_reg.loaded && (st_reg.wave_len >= `SCM_LEN_MIN) &&
		(st_reg.wave_len <= len_max) &&
		((st_reg.mode == SCM_MODE_SLOW) ||
		((st_reg.wave_len & `SCM_FAST_STEP_MASK) == 25'h0000000));

	always_comb begin
		if (st_reg.src == SCM_SRC_INTERNAL) begin
			// Rates at or above clk give one fetch every cycle
			tick = (st_reg.freq >= `SCM_CLK_HZ) || (acc_sum >= {1'b0, `SCM_CLK_HZ});
		end else begin
			tick = clk_conn_i && !st_reg.ext_prev;
		end
	end

	// ==========================================
	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.err = '0;
		st_next.err_valid = 1'b0;
		st_next.ext_prev = clk_conn_i;
		if (st_reg.src == SCM_SRC_INTERNAL && st_reg.freq < `SCM_CLK_HZ) begin
			st_next.acc = tick ? 27'(acc_sum - {1'b0, `SCM_CLK_HZ}) : acc_sum[26:0];
		end
		if (st_reg.src == SCM_SRC_INTERNAL && tick) begin
			st_next.conn = !st_reg.conn;
		end
		if (tick || st_reg.run == SCM_ST_IDLE) begin
			st_next.gap = 27'h0000000;
		end else if (st_reg.gap < `SCM_EXT_GAP_CYC) begin
			st_next.gap = st_reg.gap + 27'h0000001;
		end
		case (st_reg.run)
			SCM_ST_IDLE: begin
			end
			SCM_ST_RUN: begin
				if (tick) begin
					st_next.dac = sample_data;
					st_next.addr = (st_reg.addr + 25'h0000001 >= st_reg.wave_len) ?
						25'h0000000 : st_reg.addr + 25'h0000001;
				end
				if (st_reg.src == SCM_SRC_EXT_FAST &&
					st_reg.gap >= `SCM_EXT_GAP_CYC) begin
					st_next.run = SCM_ST_IDLE;
					st_next.err.ext_clock_low = 1'b1;
					st_next.err_valid = 1'b1;
				end
			end
			default: begin
				st_next.run = SCM_ST_IDLE;
			end
		endcase
		if (cmd_valid) begin
			case (cmd.op)
				SCM_OP_SET_FREQ: begin
					if (st_reg.segmented) begin
						st_next.err.seg_locked = 1'b1;
						st_next.err_valid = 1'b1;
					end else if (!in_range) begin
						st_next.err.freq_range = 1'b1;
						st_next.err_valid = 1'b1;
					end else begin
						st_next.freq = cmd.freq_hz;
						st_next.acc = 27'h0000000;
						st_next.src = SCM_SRC_INTERNAL;
						if (cmd.freq_hz < `SCM_BAND_LO_HZ) begin
							st_next.mode = SCM_MODE_SLOW;
						end else if (cmd.freq_hz > `SCM_BAND_HI_HZ) begin
							st_next.mode = SCM_MODE_FAST;
						end else if (cmd.mode_arg == SCM_ARG_SLOW) begin
							st_next.mode = SCM_MODE_SLOW;
						end else if (cmd.mode_arg == SCM_ARG_FAST) begin
							st_next.mode = SCM_MODE_FAST;
						end
					end
				end
				SCM_OP_SET_SRC: begin
					st_next.src = cmd.src;
					if (cmd.src == SCM_SRC_EXT_SLOW) begin
						st_next.mode = SCM_MODE_SLOW;
					end else if (cmd.src == SCM_SRC_EXT_FAST) begin
						st_next.mode = SCM_MODE_FAST;
					end
				end
				SCM_OP_LOAD_WAVE: begin
					st_next.run = SCM_ST_IDLE;
					st_next.addr = 25'h0000000;
					st_next.loaded = 1'b1;
					st_next.wave_len = cmd.wave_len;
					st_next.segmented = cmd.segmented_waveform;
					st_next.seg_freq = cmd.seg_freq_hz;
					st_next.err.wave_short = cmd.wave_len < `SCM_LEN_MIN;
					st_next.err.wave_long = cmd.wave_len > len_max;
					st_next.err.wave_step = (st_reg.mode == SCM_MODE_FAST) &&
						((cmd.wave_len & `SCM_FAST_STEP_MASK) != 25'h0000000);
					st_next.err_valid = st_next.err.wave_short ||
						st_next.err.wave_long || st_next.err.wave_step;
				end
				SCM_OP_TRIGGER: begin
					if (len_ok) begin
						st_next.run = SCM_ST_RUN;
						st_next.gap = 27'h0000000;
					end
				end
				SCM_OP_LOAD_SETUP: begin
					st_next.src = SCM_SRC_INTERNAL;
				end
				SCM_OP_STOP: begin
					st_next.run = SCM_ST_IDLE;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '{src: SCM_SRC_INTERNAL, mode: SCM_MODE_SLOW,
				freq: `SCM_RST_FREQ_HZ, run: SCM_ST_IDLE, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================
	// Outputs
	assign clk_conn_o = st_reg.conn;
	assign clk_conn_oe = (st_reg.src == SCM_SRC_INTERNAL);
	assign sample_rd_en = (st_reg.run == SCM_ST_RUN) && tick;
	assign sample_addr = st_reg.addr;
	assign dac_data = st_reg.dac;
	assign running = (st_reg.run == SCM_ST_RUN);
	assign mode = st_reg.mode;
	assign clock_source = st_reg.src;
	assign freq_report = st_reg.segmented ? st_reg.seg_freq : st_reg.freq;
	assign err_valid = st_reg.err_valid;
	assign err = st_reg.err;

	// ==========================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic set_ok;
	assign set_ok = cmd_valid && cmd.op == SCM_OP_SET_FREQ && in_range &&
		!st_reg.segmented;

	freq_taken_a: assert property (set_ok |=> st_reg.freq == $past(cmd.freq_hz))
		else $error("frequency not taken");
	fetch_step_a: assert property (sample_rd_en && st_reg.wave_len > 25'd1 &&
		st_reg.addr == 25'h0000000 && !cmd_valid |=> st_reg.addr == 25'h0000001)
		else $error("fetch address did not advance");
	band_forced_a: assert property (set_ok && cmd.freq_hz > `SCM_BAND_HI_HZ
		|=> mode == SCM_MODE_FAST)
		else $error("fast mode not forced");
	band_keep_a: assert property (set_ok && cmd.freq_hz >= `SCM_BAND_LO_HZ &&
		cmd.freq_hz <= `SCM_BAND_HI_HZ && cmd.mode_arg == SCM_ARG_NONE
		|=> $stable(mode))
		else $error("mode changed without argument");
	step_err_a: assert property (cmd_valid && cmd.op == SCM_OP_LOAD_WAVE &&
		mode == SCM_MODE_FAST && cmd.wave_len[1:0] != 2'b00
		|=> err_valid && err.wave_step)
		else $error("fast step error missing");
	short_err_a: assert property (cmd_valid && cmd.op == SCM_OP_LOAD_WAVE &&
		cmd.wave_len < `SCM_LEN_MIN |=> err_valid && err.wave_short)
		else $error("short waveform error missing");
	conn_output_a: assert property (set_ok |=> clk_conn_oe)
		else $error("connector not output after frequency write");
	conn_input_a: assert property (cmd_valid && cmd.op == SCM_OP_SET_SRC &&
		cmd.src != SCM_SRC_INTERNAL |=> !clk_conn_oe)
		else $error("connector not input for external source");
	seg_lock_a: assert property (cmd_valid && cmd.op == SCM_OP_SET_FREQ &&
		st_reg.segmented |=> $stable(st_reg.freq) && err.seg_locked)
		else $error("frequency changed on segmented waveform");
	setup_int_a: assert property (cmd_valid && cmd.op == SCM_OP_LOAD_SETUP
		|=> clock_source == SCM_SRC_INTERNAL)
		else $error("setup load left external clock");
	ext_low_a: assert property (tick ##1 (running && !tick &&
		!cmd_valid && clock_source == SCM_SRC_EXT_FAST) [*8] ##1
		(running && !tick && !cmd_valid) [*8] ##1
		(running && !tick && !cmd_valid) [*5]
		|=> !running ##0 err.ext_clock_low)
		else $error("slow external clock did not halt output");
	range_rej_a: assert property (cmd_valid && cmd.op == SCM_OP_SET_FREQ &&
		!in_range |=> $stable(st_reg.freq) && $stable(mode) && err.freq_range)
		else $error("out of range frequency accepted");

	run_cov_c: cover property (running && sample_rd_en);
	ext_halt_c: cover property (err_valid && err.ext_clock_low);
	band_slow_c: cover property (set_ok && cmd.mode_arg == SCM_ARG_SLOW &&
		cmd.freq_hz == 27'd2500000);
	ext_run_c: cover property (running && clock_source == SCM_SRC_EXT_SLOW);
endmodule

// File: test/scm_ext_clk_model.sv
`timescale 1ns/1ps
// ==========================================
// External sample clock source at the rear connector
module scm_ext_clk_model (
	input wire logic clk, // Bench clock
	input wire logic drive_en, // High while the connector is an input
	input wire logic run, // Source delivers a clock
	input wire logic [7:0] half_cyc, // Half period in clk cycles
	output logic pin // Level offered to the connector
);
	logic [7:0] cnt_reg = 8'h00;
	logic lvl_reg = 1'b0;
	// Stands still between bursts, as a halted source does
	always @(posedge clk) begin
		if (run && drive_en) begin
			cnt_reg <= (cnt_reg + 8'h01 >= half_cyc) ? 8'h00 : cnt_reg + 8'h01;
			if (cnt_reg + 8'h01 >= half_cyc) lvl_reg <= ~lvl_reg;
		end
	end
	// Released line shows the inverse of the last level
	assign pin = drive_en ? lvl_reg : ~lvl_reg;
endmodule

// File: test/scm_sample_clock_tb_top.sv
`timescale 1ns/1ps
`include "scm_map.svh"
module scm_sample_clock_tb_top;
	import scm_pkg::*;
	logic clk, resetn, large_memory, cmd_valid, run_ext, pend, c0;
	scm_cmd_t cmd;
	logic clk_conn_i, clk_conn_o, clk_conn_oe, sample_rd_en, ext_pin, running;
	logic [24:0] sample_addr, exp_addr, wlen;
	logic [15:0] sample_data, dac_data, key;
	logic [26:0] freq_report;
	logic err_valid;
	scm_err_t err;
	scm_mode_t mode;
	scm_src_t clock_source;
	logic [31:0] seed = 32'd99;
	logic [15:0] dac_q[$];
	scm_err_t err_q[$];
	int n_fail = 0;
	int n_checks = 0;
	int n_rd = 0;
	// ==========================================
	// Clock, connector wire, buffer and partner
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	assign clk_conn_i = clk_conn_oe ? clk_conn_o : ext_pin;
	assign sample_data = key ^ sample_addr[15:0];
	scm_ext_clk_model u_ext (.clk(clk), .drive_en(~clk_conn_oe),
		.run(run_ext), .half_cyc(8'h04), .pin(ext_pin));
	scm_sample_clock u_dut (.clk(clk), .resetn(resetn),
		.large_memory(large_memory), .cmd_valid(cmd_valid), .cmd(cmd),
		.clk_conn_i(clk_conn_i), .clk_conn_o(clk_conn_o),
		.clk_conn_oe(clk_conn_oe), .sample_rd_en(sample_rd_en),
		.sample_addr(sample_addr), .sample_data(sample_data),
		.dac_data(dac_data), .running(running), .mode(mode),
		.clock_source(clock_source), .freq_report(freq_report),
		.err_valid(err_valid), .err(err));
	// ==========================================
	// Helpers
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic close_out();
		if (err_q.size() != 0) n_fail++;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic send(input scm_op_t op, input logic [26:0] f,
		input scm_mode_arg_t m, input scm_src_t s, input logic [24:0] l,
		input logic sg);
		@(posedge clk) #2;
		cmd_valid = 1'b1;
		cmd = '{op, f, m, s, l, sg, 27'd100000};
		if (op == SCM_OP_LOAD_WAVE) begin
			exp_addr = 25'h0000000;
			wlen = l;
		end
		@(posedge clk) #2;
		cmd_valid = 1'b0;
		@(posedge clk) #2;
	endtask
	task automatic fq(input logic [26:0] f, input scm_mode_arg_t m,
		input scm_mode_t e);
		send(SCM_OP_SET_FREQ, f, m, SCM_SRC_INTERNAL, 25'h0000000, 1'b0);
		chk("mode", mode, e);
		chk("freq", freq_report, f);
		chk("conn_oe", clk_conn_oe, 1'b1);
		chk("source", clock_source, SCM_SRC_INTERNAL);
	endtask
	task automatic wave(input logic [24:0] l, input logic [5:0] e);
		if (e != 6'h00) err_q.push_back(scm_err_t'(e));
		send(SCM_OP_LOAD_WAVE, 27'h0, SCM_ARG_NONE, SCM_SRC_INTERNAL, l, 1'b0);
	endtask
	// ==========================================
	// Monitor: fetch address, presented sample, error entries
	always @(posedge clk) begin
		if (pend) chk("dac_data", dac_data, dac_q.pop_front());
		pend = sample_rd_en === 1'b1;
		if (pend) begin
			chk("addr", sample_addr, exp_addr);
			n_rd++;
			dac_q.push_back(key ^ exp_addr[15:0]);
			exp_addr = (exp_addr + 25'h0000001 == wlen) ? 25'h0 : exp_addr + 1;
		end
		if (err_valid === 1'b1) begin
			if (err_q.size() == 0) chk("err_extra", 32'h1, 32'h0);
			else chk("err", err, err_q.pop_front());
		end
	end
	initial begin
		#(25ns * 20000);
		n_fail++;
		close_out();
	end
	// ==========================================
	// Main sequence
	initial begin
		resetn = 1'b0;
		cmd_valid = 1'b0;
		cmd = '0;
		large_memory = 1'b0;
		run_ext = 1'b0;
		pend = 1'b0;
		exp_addr = '0;
		wlen = 25'd24;
		key = 16'(xs());
		repeat (8) @(posedge clk);
		#2 resetn = 1'b1;
		repeat (3) @(posedge clk);
		#2 chk("rst_src", clock_source, SCM_SRC_INTERNAL);
		chk("rst_mode", mode, SCM_MODE_SLOW);
		chk("rst_freq", freq_report, `SCM_RST_FREQ_HZ);
		chk("rst_oe", clk_conn_oe, 1'b1);
		fq(27'd1000000, SCM_ARG_FAST, SCM_MODE_SLOW);
		fq(27'd5000000, SCM_ARG_SLOW, SCM_MODE_FAST);
		fq(27'd3000000, SCM_ARG_NONE, SCM_MODE_FAST);
		fq(27'd2000000, SCM_ARG_SLOW, SCM_MODE_SLOW);
		fq(27'd4000000, SCM_ARG_FAST, SCM_MODE_FAST);
		fq(27'd10, SCM_ARG_FAST, SCM_MODE_SLOW);
		fq(27'd105000000, SCM_ARG_SLOW, SCM_MODE_FAST);
		fq(27'd4000001 + 27'(xs() % 101000000), SCM_ARG_SLOW, SCM_MODE_FAST);
		fq(27'd2500000, SCM_ARG_SLOW, SCM_MODE_SLOW);
		err_q.push_back(scm_err_t'(6'h20));
		send(SCM_OP_SET_FREQ, 27'd9, SCM_ARG_FAST, SCM_SRC_INTERNAL, 25'h0, 1'b0);
		err_q.push_back(scm_err_t'(6'h20));
		send(SCM_OP_SET_FREQ, 27'd105000001, SCM_ARG_FAST, SCM_SRC_INTERNAL,
			25'h0, 1'b0);
		chk("kept_freq", freq_report, 27'd2500000);
		chk("kept_mode", mode, SCM_MODE_SLOW);
		send(SCM_OP_SET_SRC, 27'h0, SCM_ARG_NONE, SCM_SRC_EXT_SLOW, 25'h0, 1'b0);
		chk("ext_oe", clk_conn_oe, 1'b0);
		chk("ext_src", clock_source, SCM_SRC_EXT_SLOW);
		wave(25'd23, 6'h08);
		wave(25'd4000001, 6'h02);
		large_memory = 1'b1;
		wave(25'd4000001, 6'h00);
		fq(27'd40000000, SCM_ARG_NONE, SCM_MODE_FAST);
		wave(25'd26, 6'h04);
		wave(25'd20, 6'h08);
		wave(25'd24, 6'h00);
		send(SCM_OP_TRIGGER, 27'h0, SCM_ARG_NONE, SCM_SRC_INTERNAL, 25'h0, 1'b0);
		chk("running", running, 1'b1);
		c0 = clk_conn_o;
		@(posedge clk) #2;
		chk("conn_toggle", clk_conn_o, !c0);
		repeat (60) @(posedge clk);
		fq(27'd10000000, SCM_ARG_NONE, SCM_MODE_FAST);
		n_rd = 0;
		repeat (40) @(posedge clk);
		#2 chk("fetch_rate", n_rd, 32'd10);
		send(SCM_OP_STOP, 27'h0, SCM_ARG_NONE, SCM_SRC_INTERNAL, 25'h0, 1'b0);
		send(SCM_OP_SET_SRC, 27'h0, SCM_ARG_NONE, SCM_SRC_EXT_FAST, 25'h0, 1'b0);
		chk("fast_mode", mode, SCM_MODE_FAST);
		wave(25'd24, 6'h00);
		run_ext = 1'b1;
		send(SCM_OP_TRIGGER, 27'h0, SCM_ARG_NONE, SCM_SRC_INTERNAL, 25'h0, 1'b0);
		repeat (40) @(posedge clk);
		#2 chk("ext_run", running, 1'b1);
		run_ext = 1'b0;
		err_q.push_back(scm_err_t'(6'h01));
		repeat (30) @(posedge clk);
		#2 chk("ext_halt", running, 1'b0);
		send(SCM_OP_LOAD_WAVE, 27'h0, SCM_ARG_NONE, SCM_SRC_INTERNAL, 25'd24, 1'b1);
		chk("seg_freq", freq_report, 27'd100000);
		err_q.push_back(scm_err_t'(6'h10));
		send(SCM_OP_SET_FREQ, 27'd5000000, SCM_ARG_NONE, SCM_SRC_INTERNAL,
			25'h0, 1'b0);
		chk("seg_kept", freq_report, 27'd100000);
		chk("seg_src", clock_source, SCM_SRC_EXT_FAST);
		send(SCM_OP_LOAD_SETUP, 27'h0, SCM_ARG_NONE, SCM_SRC_EXT_FAST, 25'h0, 1'b0);
		chk("setup_src", clock_source, SCM_SRC_INTERNAL);
		chk("setup_oe", clk_conn_oe, 1'b1);
		repeat (5) @(posedge clk);
		close_out();
	end
endmodule
